// ===== hdl/cci_compare_irq.sv
// Behaviour
// - With the processor idle the channel can still work fully when idle conditions hold.
// - In idle the channel runs only with its stop-in-idle bit 13 clear, chosen timer enabled, timer stop-in-idle clear.
// - A compare match can raise an interrupt request in any configured match mode.
// - Outside pulse-width mode a compare event sets the channel compare flag.
// - The compare request is issued only with the compare enable set, the flag sets regardless.
// - In pulse-width mode the period event sets the flag of the selected timer, a or b.
// - In pulse-width mode the timer request needs that timer's enable; software clears the timer flag.
// - In pulse-width mode the channel compare flag is never set.
// - Mode codes 110 and 111 are pulse-width mode, 001 to 101 are compare match modes.
// - Timer select bit 3 clear picks timer a, set picks timer b.
module cci_compare_irq #(
    parameter int TIMER_W = cci_pkg::CCI_TIMER_W
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // processor state and channel control
    input wire logic cpu_idle_i,
    input wire logic [cci_pkg::CCI_CTRL_W-1:0] compare_control_reg_i,
    // timer bases
    input wire logic timer_a_enable_i,
    input wire logic timer_b_enable_i,
    input wire logic timer_a_stop_in_idle_i,
    input wire logic timer_b_stop_in_idle_i,
    input wire logic [TIMER_W-1:0] timer_a_count_i,
    input wire logic [TIMER_W-1:0] timer_b_count_i,
    input wire logic timer_a_period_hit_i,
    input wire logic timer_b_period_hit_i,
    // compare values
    input wire logic [TIMER_W-1:0] compare_primary_i,
    input wire logic [TIMER_W-1:0] compare_secondary_i,
    // interrupt enables
    input wire logic compare_irq_enable_i,
    input wire logic timer_a_irq_enable_i,
    input wire logic timer_b_irq_enable_i,
    // software flag clears
    input wire logic compare_irq_flag_clear_i,
    input wire logic timer_a_irq_flag_clear_i,
    input wire logic timer_b_irq_flag_clear_i,
    // flags, requests and status
    output logic compare_irq_flag_o,
    output logic timer_a_irq_flag_o,
    output logic timer_b_irq_flag_o,
    output logic compare_irq_req_o,
    output logic timer_a_irq_req_o,
    output logic timer_b_irq_req_o,
    output logic channel_run_o,
    output logic compare_event_o
);
    import cci_pkg::*;

    typedef struct packed {
        logic cmp_flag;
        logic ta_flag;
        logic tb_flag;
        logic cmp_req;
        logic ta_req;
        logic tb_req;
        logic run;
        logic event_seen;
    } cci_state_t;

    cci_state_t state;
    cci_state_t next_state;

    logic [CCI_MODE_W-1:0] mode;
    logic stop_in_idle;
    logic timer_select;
    logic sel_enable;
    logic sel_sidl;
    logic run;
    logic [TIMER_W-1:0] sel_count;
    logic [CCI_NUM_CMP-1:0] hit;
    logic [TIMER_W-1:0] cmp_value [CCI_NUM_CMP];
    logic cmp_event;
    logic pwm_a_event;
    logic pwm_b_event;

    // control field decode
    assign mode = compare_control_reg_i[CCI_MODE_LSB +: CCI_MODE_W];
    assign stop_in_idle = compare_control_reg_i[CCI_SIDL_BIT];
    assign timer_select = compare_control_reg_i[CCI_TSEL_BIT];

    // time base choice
    assign sel_count = timer_select ? timer_b_count_i : timer_a_count_i;
    assign sel_enable = timer_select ? timer_b_enable_i : timer_a_enable_i;
    assign sel_sidl = timer_select ? timer_b_stop_in_idle_i : timer_a_stop_in_idle_i;

    // outside idle always running; in idle all three conditions must hold
    assign run = !cpu_idle_i || (!stop_in_idle && sel_enable && !sel_sidl);

    // one detector per compare register
    assign cmp_value[CCI_CMP_PRIMARY] = compare_primary_i;
    assign cmp_value[CCI_CMP_SECONDARY] = compare_secondary_i;
    for (genvar g = 0; g < CCI_NUM_CMP; g++) begin : g_det
        cci_match_detect #(
            .WIDTH(TIMER_W)
        ) u_det (
            .ref_clk_i(ref_clk_i),
            .rst_i(rst_i),
            .run_i(run),
            .count_i(sel_count),
            .value_i(cmp_value[g]),
            .hit_o(hit[g])
        );
    end

    // dual modes end their pulse on the secondary match, simple modes on the primary
    always_comb begin
        cmp_event = 1'b0;
        if (cci_is_compare(mode)) begin
            cmp_event = cci_is_dual(mode) ? hit[CCI_CMP_SECONDARY] : hit[CCI_CMP_PRIMARY];
        end
    end

    // period events only in pwm, routed to the selected timer's flag
    assign pwm_a_event = run && cci_is_pwm(mode) && !timer_select && timer_a_period_hit_i;
    assign pwm_b_event = run && cci_is_pwm(mode) && timer_select && timer_b_period_hit_i;

    // flags: set wins over a clear in the same clock; nothing but software or reset clears
    always_comb begin
        next_state = state;
        next_state.run = run;
        next_state.event_seen = cmp_event;
        next_state.cmp_flag = (state.cmp_flag && !compare_irq_flag_clear_i) || cmp_event;
        next_state.ta_flag = (state.ta_flag && !timer_a_irq_flag_clear_i) || pwm_a_event;
        next_state.tb_flag = (state.tb_flag && !timer_b_irq_flag_clear_i) || pwm_b_event;
        next_state.cmp_req = next_state.cmp_flag && compare_irq_enable_i;
        next_state.ta_req = next_state.ta_flag && timer_a_irq_enable_i;
        next_state.tb_req = next_state.tb_flag && timer_b_irq_enable_i;
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // registered outputs
    assign compare_irq_flag_o = state.cmp_flag;
    assign timer_a_irq_flag_o = state.ta_flag;
    assign timer_b_irq_flag_o = state.tb_flag;
    assign compare_irq_req_o = state.cmp_req;
    assign timer_a_irq_req_o = state.ta_req;
    assign timer_b_irq_req_o = state.tb_req;
    assign channel_run_o = state.run;
    assign compare_event_o = state.event_seen;

    // checks
    property p_active_awake;
        @(posedge ref_clk_i) disable iff (rst_i)
        !cpu_idle_i |=> channel_run_o;
    endproperty
    a_active_awake: assert property (p_active_awake) else $error("channel halted while not idle");

    property p_idle_stop;
        @(posedge ref_clk_i) disable iff (rst_i)
        (cpu_idle_i && (stop_in_idle || !sel_enable || sel_sidl)) |=> !channel_run_o;
    endproperty
    a_idle_stop: assert property (p_idle_stop) else $error("channel ran in idle against its conditions");

    property p_cmp_sets_flag;
        @(posedge ref_clk_i) disable iff (rst_i)
        (run && cci_is_compare(mode) && !cci_is_dual(mode) && hit[CCI_CMP_PRIMARY])
            |=> compare_irq_flag_o && compare_event_o;
    endproperty
    a_cmp_sets_flag: assert property (p_cmp_sets_flag) else $error("compare match did not set flag");

    // dual modes report on the secondary register only
    property p_dual_sets_flag;
        @(posedge ref_clk_i) disable iff (rst_i)
        (cci_is_dual(mode) && hit[CCI_CMP_SECONDARY]) |=> compare_irq_flag_o && compare_event_o;
    endproperty
    a_dual_sets_flag: assert property (p_dual_sets_flag) else $error("secondary match did not set flag");

    property p_flag_sticky;
        @(posedge ref_clk_i) disable iff (rst_i)
        (compare_irq_flag_o && !compare_irq_flag_clear_i) |=> compare_irq_flag_o;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("compare flag dropped without clear");

    property p_req_gated;
        @(posedge ref_clk_i) disable iff (rst_i)
        compare_irq_req_o |-> compare_irq_flag_o && $past(compare_irq_enable_i);
    endproperty
    a_req_gated: assert property (p_req_gated) else $error("compare request without flag or enable");

    property p_pwm_timer_a;
        @(posedge ref_clk_i) disable iff (rst_i)
        (run && cci_is_pwm(mode) && !timer_select && timer_a_period_hit_i)
            |=> timer_a_irq_flag_o && (timer_a_irq_req_o == $past(timer_a_irq_enable_i));
    endproperty
    a_pwm_timer_a: assert property (p_pwm_timer_a) else $error("period event missed timer a flag");

    property p_pwm_timer_b;
        @(posedge ref_clk_i) disable iff (rst_i)
        (run && cci_is_pwm(mode) && timer_select && timer_b_period_hit_i && !timer_b_irq_flag_o)
            |=> timer_b_irq_flag_o ##1 (timer_b_irq_flag_o || $past(timer_b_irq_flag_clear_i));
    endproperty
    a_pwm_timer_b: assert property (p_pwm_timer_b) else $error("period event missed timer b flag");

    property p_timer_req;
        @(posedge ref_clk_i) disable iff (rst_i)
        $rose(timer_b_irq_req_o) |-> timer_b_irq_flag_o && $past(timer_b_irq_enable_i);
    endproperty
    a_timer_req: assert property (p_timer_req) else $error("timer request without flag or enable");

    // timer a request needs its own flag and enable as well
    property p_timer_a_req;
        @(posedge ref_clk_i) disable iff (rst_i)
        $rose(timer_a_irq_req_o) |-> timer_a_irq_flag_o && $past(timer_a_irq_enable_i);
    endproperty
    a_timer_a_req: assert property (p_timer_a_req) else $error("timer a request without flag or enable");

    property p_pwm_no_cmp_flag;
        @(posedge ref_clk_i) disable iff (rst_i)
        $rose(compare_irq_flag_o) |-> !cci_is_pwm($past(mode)) && $past(mode) != CCI_MODE_OFF;
    endproperty
    a_pwm_no_cmp_flag: assert property (p_pwm_no_cmp_flag) else $error("compare flag set in pwm or off");

    property p_freeze;
        @(posedge ref_clk_i) disable iff (rst_i)
        !run |=> !$rose(compare_irq_flag_o) && !$rose(timer_a_irq_flag_o) && !$rose(timer_b_irq_flag_o);
    endproperty
    a_freeze: assert property (p_freeze) else $error("flag rose while channel frozen");
endmodule

// ===== hdl/cci_pkg.sv
package cci_pkg;
    // control register layout
    localparam int CCI_CTRL_W = 16;
    localparam int CCI_TIMER_W = 16;
    localparam int CCI_SIDL_BIT = 13;
    localparam int CCI_TSEL_BIT = 3;
    localparam int CCI_MODE_LSB = 0;
    localparam int CCI_MODE_W = 3;
    localparam int CCI_NUM_CMP = 2;
    localparam int CCI_CMP_PRIMARY = 0;
    localparam int CCI_CMP_SECONDARY = 1;

    // mode codes
    localparam logic [CCI_MODE_W-1:0] CCI_MODE_OFF = 3'h0;
    localparam logic [CCI_MODE_W-1:0] CCI_MODE_FORCE_LOW = 3'h1;
    localparam logic [CCI_MODE_W-1:0] CCI_MODE_FORCE_HIGH = 3'h2;
    localparam logic [CCI_MODE_W-1:0] CCI_MODE_TOGGLE = 3'h3;
    localparam logic [CCI_MODE_W-1:0] CCI_MODE_SINGLE_PULSE = 3'h4;
    localparam logic [CCI_MODE_W-1:0] CCI_MODE_CONT_PULSE = 3'h5;
    localparam logic [CCI_MODE_W-1:0] CCI_MODE_PWM = 3'h6;
    localparam logic [CCI_MODE_W-1:0] CCI_MODE_PWM_FAULT = 3'h7;

    // pwm covers both pwm codes
    function automatic logic cci_is_pwm(input logic [CCI_MODE_W-1:0] mode);
        return (mode == CCI_MODE_PWM) || (mode == CCI_MODE_PWM_FAULT);
    endfunction

    // dual compare modes report on the secondary match
    function automatic logic cci_is_dual(input logic [CCI_MODE_W-1:0] mode);
        return (mode == CCI_MODE_SINGLE_PULSE) || (mode == CCI_MODE_CONT_PULSE);
    endfunction

    // compare match modes are codes 1 to 5
    function automatic logic cci_is_compare(input logic [CCI_MODE_W-1:0] mode);
        return (mode != CCI_MODE_OFF) && !cci_is_pwm(mode);
    endfunction
endpackage

// ===== hdl/cci_match_detect.sv
module cci_match_detect #(
    parameter int WIDTH = cci_pkg::CCI_TIMER_W
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // gating and operands
    input wire logic run_i,
    input wire logic [WIDTH-1:0] count_i,
    input wire logic [WIDTH-1:0] value_i,
    // match pulse
    output logic hit_o
);
    import cci_pkg::*;

    typedef struct packed {
        logic prev_eq;
    } cci_md_state_t;

    cci_md_state_t state;
    cci_md_state_t next_state;
    logic eq;

    // a prescaled timer holds a count for many clocks, so only the first equal clock counts
    assign eq = (count_i == value_i);
    assign hit_o = run_i && eq && !state.prev_eq;

    // history frozen while the channel is halted
    always_comb begin
        next_state = state;
        if (run_i) begin
            next_state.prev_eq = eq;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end
endmodule

// ===== tb/cci_timer_model.sv
module cci_timer_model #(
    parameter int PER = 40
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // control
    input wire logic enable_i,
    // time base
    output logic [15:0] count_o,
    output logic hit_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // counts while enabled, wraps at PER with a one-cycle hit; holds when off
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            count_o <= 16'h0;
            hit_o <= 1'b0;
        end else begin
            hit_o <= enable_i && (count_o == PER);
            if (enable_i) begin
                count_o <= (count_o == PER) ? 16'h0 : count_o + 16'h1;
            end
        end
    end
endmodule

// ===== tb/cci_compare_irq_tb.sv
module cci_compare_irq_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import cci_pkg::*;

    logic clk = 0, rst = 1, idle = 0, ena = 1, enb = 1, sia = 0, sib = 0;
    logic cie = 0, aie = 0, bie = 0, cclr = 0, aclr = 0, bclr = 0;
    logic [15:0] ctl = 16'h0, cp = 16'h0, cs = 16'h0, cnta, cntb, last = 16'h0;
    logic hita, hitb, cf, af, bf, cr, ar, br, run, ev, paf = 0, pbf = 0;
    logic [31:0] lfsr = 32'hed18;
    logic [31:0] q[$];
    int fails = 0, n_checks = 0;

    always #2 clk = ~clk;

    cci_timer_model #(.PER(40)) tmr_a (.ref_clk_i(clk), .rst_i(rst), .enable_i(ena), .count_o(cnta), .hit_o(hita));
    cci_timer_model #(.PER(56)) tmr_b (.ref_clk_i(clk), .rst_i(rst), .enable_i(enb), .count_o(cntb), .hit_o(hitb));

    cci_compare_irq #(.TIMER_W(16)) dut (
        .ref_clk_i(clk), .rst_i(rst), .cpu_idle_i(idle), .compare_control_reg_i(ctl),
        .timer_a_enable_i(ena), .timer_b_enable_i(enb),
        .timer_a_stop_in_idle_i(sia), .timer_b_stop_in_idle_i(sib),
        .timer_a_count_i(cnta), .timer_b_count_i(cntb),
        .timer_a_period_hit_i(hita), .timer_b_period_hit_i(hitb),
        .compare_primary_i(cp), .compare_secondary_i(cs),
        .compare_irq_enable_i(cie), .timer_a_irq_enable_i(aie), .timer_b_irq_enable_i(bie),
        .compare_irq_flag_clear_i(cclr), .timer_a_irq_flag_clear_i(aclr), .timer_b_irq_flag_clear_i(bclr),
        .compare_irq_flag_o(cf), .timer_a_irq_flag_o(af), .timer_b_irq_flag_o(bf),
        .compare_irq_req_o(cr), .timer_a_irq_req_o(ar), .timer_b_irq_req_o(br),
        .channel_run_o(run), .compare_event_o(ev));

    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    // an unexpected result finds an empty queue and shows up as all ones
    task automatic pop(input string nm, input logic [31:0] g);
        logic [31:0] e;
        e = 32'hffffffff;
        if (q.size() > 0) e = q.pop_front();
        chk(nm, e, g);
    endtask

    task automatic wait_q;
        for (int i = 0; i < 150 && q.size() > 0; i++) tick(1);
        chk("queue_empty", 0, 32'(q.size()));
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // watcher: events carry the selected count of the cycle before
    always @(negedge clk) begin
        if (ev === 1'b1) pop("compare_event", {16'h0, last});
        if (af === 1'b1 && paf === 1'b0) pop("timer_a_flag", 32'h10000);
        if (bf === 1'b1 && pbf === 1'b0) pop("timer_b_flag", 32'h20000);
        last = ctl[3] ? cntb : cnta;
        paf = af;
        pbf = bf;
    end

    initial begin
        #100000;
        fails++;
        stop_test();
    end

    initial begin
        logic [15:0] v;
        tick(4);
        rst = 1'b0;
        tick(1);
        // compare modes on a random timer, enable and value
        for (int m = 1; m < 6; m++) begin
            lfsr = nxt(lfsr);
            cie = lfsr[8];
            v = lfsr[15:0] % (lfsr[9] ? 16'd56 : 16'd40);
            if (m < 4) cp = v;
            else cs = v;
            ctl = {12'h0, lfsr[9], 3'(m)};
            q.push_back({16'h0, v});
            wait_q();
            chk("compare_flag", 1, 32'(cf));
            chk("compare_req", 32'(cie), 32'(cr));
            tick(3);
            chk("compare_flag_held", 1, 32'(cf));
            cclr = 1'b1;
            tick(1);
            cclr = 1'b0;
            tick(1);
            chk("compare_flag_clr", 0, 32'(cf | cr));
        end
        // mode off: a standing match must raise nothing
        ctl = {12'h0, 1'b0, CCI_MODE_OFF};
        cp = 16'd5;
        cs = 16'd5;
        tick(60);
        chk("compare_flag_off", 0, 32'(cf | cr));
        $display("test compare done");
        // both pwm codes on both timers; other timer hits must be ignored
        for (int k = 0; k < 4; k++) begin
            lfsr = nxt(lfsr);
            aie = lfsr[3];
            bie = lfsr[4];
            ctl = {12'h0, 1'(k), 3'(6 + k / 2)};
            q.push_back(k[0] ? 32'h20000 : 32'h10000);
            wait_q();
            chk("timer_req", 32'(k[0] ? bie : aie), 32'(k[0] ? br : ar));
            chk("compare_flag_pwm", 0, 32'(cf));
            aclr = 1'b1;
            bclr = 1'b1;
            tick(1);
            aclr = 1'b0;
            bclr = 1'b0;
            tick(1);
            chk("timer_flag_clr", 0, 32'(af | bf));
        end
        $display("test pwm done");
        // idle: runs when allowed, freezes on each failed condition
        ctl = 16'h0001;
        idle = 1'b1;
        v = 16'd17;
        cp = v;
        q.push_back(32'(v));
        wait_q();
        chk("run_idle", 1, 32'(run));
        for (int f = 0; f < 3; f++) begin
            // clear first so a leaked match would show on the frozen flag
            cclr = 1'b1;
            tick(1);
            cclr = 1'b0;
            ctl[13] = (f == 0);
            sia = (f == 1);
            ena = (f != 2);
            tick(2);
            chk("run_blocked", 0, 32'(run));
            tick(90);
            chk("flag_frozen", 0, 32'(cf));
            q.push_back(32'(v));
            ctl[13] = 1'b0;
            sia = 1'b0;
            ena = 1'b1;
            wait_q();
        end
        ctl[13] = 1'b1;
        idle = 1'b0;
        tick(2);
        chk("run_awake", 1, 32'(run));
        $display("test idle done");
        stop_test();
    end
endmodule
